//--- core/wdw_top.sv
/*
 Windowed watchdog timer with an AXI4-Lite register slave.
 Holds the configuration word, the reset control flags, commands that
 stand for the clear and power-save instructions, the power mode and
 an interrupt with sticky status and mask.
 Assumes all inputs synchronous to mclk; wdt_reset is routed by the
 system to reset the core, not to nrst of this block.
*/
`timescale 1ns/1ps
`include "wdw_defines.svh"
module wdw_top #(
    parameter int OSC_DIV = `WDW_OSC_DIV,
    parameter int AW = 5
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dev_reset_req,
    input wire logic clk_switch_done,
    input wire logic wake_event,
    output logic osc_on,
    output logic wdt_reset,
    output wdw_pkg::wdw_mode_t power_mode,
    output logic irq
);
    import wdw_pkg::*;

    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] rctl_q;
    logic [7:0] rctl_d;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    wdw_mode_t mode_q;
    wdw_mode_t mode_d;
    logic wdt_reset_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wdw_cnt_if cnt_bus ();

    wdw_osc #(
        .DIV(OSC_DIV)
    ) u_osc (
        .mclk(mclk),
        .nrst(nrst),
        .osc(cnt_bus.osc)
    );

    wdw_scaler u_scaler (
        .mclk(mclk),
        .nrst(nrst),
        .cnt(cnt_bus.cnt)
    );

    // Known offset test
    function automatic logic addr_hit(input logic [AW-1:0] a);
        addr_hit = (a == AW'(`WDW_ADDR_CFG)) || (a == AW'(`WDW_ADDR_RCTL))
                || (a == AW'(`WDW_ADDR_CMD)) || (a == AW'(`WDW_ADDR_STAT))
                || (a == AW'(`WDW_ADDR_MASK));
    endfunction

    // -----------------------------------------------------------
    // Write channel decode
    // -----------------------------------------------------------
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    wire wr_en = wr_go && s_axi_wstrb[0];
    wire [7:0] wbyte = s_axi_wdata[7:0];
    wire wr_cfg = wr_en && (s_axi_awaddr == AW'(`WDW_ADDR_CFG));
    wire wr_rctl = wr_en && (s_axi_awaddr == AW'(`WDW_ADDR_RCTL));
    wire wr_cmd = wr_en && (s_axi_awaddr == AW'(`WDW_ADDR_CMD));
    wire wr_mask = wr_en && (s_axi_awaddr == AW'(`WDW_ADDR_MASK));
    wire wr_bad = !addr_hit(s_axi_awaddr);

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;

    // -----------------------------------------------------------
    // Read channel decode
    // -----------------------------------------------------------
    wire rd_go = s_axi_arvalid && !rvalid_q;
    wire rd_stat = rd_go && (s_axi_araddr == AW'(`WDW_ADDR_STAT));
    wire rd_bad = !addr_hit(s_axi_araddr);
    wire [7:0] rd_byte =
        (s_axi_araddr == AW'(`WDW_ADDR_CFG)) ? cfg_q :
        (s_axi_araddr == AW'(`WDW_ADDR_RCTL)) ? rctl_q :
        (s_axi_araddr == AW'(`WDW_ADDR_STAT)) ? stat_q :
        (s_axi_araddr == AW'(`WDW_ADDR_MASK)) ? mask_q : 8'h00;

    assign s_axi_arready = !rvalid_q;

    // -----------------------------------------------------------
    // Watchdog events
    // -----------------------------------------------------------
    wire in_run = (mode_q == WDW_RUN);
    wire enabled = cfg_q[`WDW_CFG_HARD]
                || rctl_q[`WDW_RCTL_SOFT];
    wire cmd_clr = wr_cmd && wbyte[`WDW_CMD_CLR];
    wire cmd_sleep = wr_cmd && wbyte[`WDW_CMD_SLEEP];
    wire cmd_idle = wr_cmd && wbyte[`WDW_CMD_IDLE] && !cmd_sleep;
    wire enter_ps = in_run && (cmd_sleep || cmd_idle);
    wire tmo = cnt_bus.timeout && enabled;
    wire win_mode = !cfg_q[`WDW_CFG_WINOFF];
    wire win_viol = cmd_clr && in_run && enabled && win_mode
                 && !cnt_bus.window_open;
    wire fire = (tmo && in_run) || win_viol;
    wire wake = !in_run && (tmo || wake_event);
    wire dev_rst = dev_reset_req || fire;

    assign cnt_bus.osc_run = enabled;
    assign cnt_bus.pre_sel = cfg_q[`WDW_CFG_PRE];
    assign cnt_bus.post_sel =
        cfg_q[`WDW_CFG_POST_MSB:`WDW_CFG_POST_LSB];
    assign cnt_bus.clr = dev_rst || clk_switch_done
                      || enter_ps || wake
                      || cmd_clr || cmd_sleep || cmd_idle
                      || !enabled;

    // -----------------------------------------------------------
    // Power mode
    // -----------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            WDW_RUN: begin
                if (cmd_sleep) begin
                    mode_d = WDW_SLEEP;
                end else if (cmd_idle) begin
                    mode_d = WDW_IDLE;
                end
            end
            WDW_SLEEP, WDW_IDLE: begin
                if (wake) begin
                    mode_d = WDW_RUN;
                end
            end
            default: begin
                mode_d = WDW_RUN;
            end
        endcase
    end

    // -----------------------------------------------------------
    // Register next values; hardware sets win over software clears
    // -----------------------------------------------------------
    always_comb begin
        cfg_d = wr_cfg ? wbyte : cfg_q;
        mask_d = wr_mask ? (wbyte & `WDW_ST_MASK) : mask_q;
        rctl_d = wr_rctl ? (wbyte & `WDW_RCTL_MASK) : rctl_q;
        if (dev_rst) begin
            rctl_d[`WDW_RCTL_SOFT] = 1'b0;
        end
        if (tmo || win_viol) begin
            rctl_d[`WDW_RCTL_TMO] = 1'b1;
        end
        if (enter_ps && cmd_sleep) begin
            rctl_d[`WDW_RCTL_SLEEP] = 1'b1;
        end
        if (enter_ps && cmd_idle) begin
            rctl_d[`WDW_RCTL_IDLE] = 1'b1;
        end
        stat_d = rd_stat ? 8'h00 : stat_q;
        stat_d[`WDW_ST_TMO] = stat_d[`WDW_ST_TMO] | tmo;
        stat_d[`WDW_ST_WIN] = stat_d[`WDW_ST_WIN] | win_viol;
        stat_d[`WDW_ST_WAKE] = stat_d[`WDW_ST_WAKE] | wake;
    end

    // -----------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `WDW_CFG_RST;
            rctl_q <= `WDW_RCTL_RST;
            stat_q <= `WDW_ST_RST;
            mask_q <= `WDW_ST_RST;
            mode_q <= WDW_RUN;
            wdt_reset_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rctl_q <= rctl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            mode_q <= mode_d;
            wdt_reset_q <= fire;
        end
    end

    // -----------------------------------------------------------
    // Bus answers
    // -----------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `WDW_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `WDW_RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_bad ? `WDW_RESP_SLVERR : `WDW_RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_byte};
                rresp_q <= rd_bad ? `WDW_RESP_SLVERR : `WDW_RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign osc_on = enabled;
    assign wdt_reset = wdt_reset_q;
    assign power_mode = mode_q;
    assign irq = |(stat_q & mask_q);
endmodule // wdw_top

//--- pkg/wdw_defines.svh
/*
 Constants of the windowed watchdog: bus offsets, field positions,
 reset values and timing figures.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef WDW_DEFINES_SVH
`define WDW_DEFINES_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WDW_MCLK_KHZ 20000
`define WDW_OSC_KHZ 32
`define WDW_OSC_DIV (`WDW_MCLK_KHZ / `WDW_OSC_KHZ)
`define WDW_PRE_SHIFT_LO 5
`define WDW_PRE_SHIFT_HI 7

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define WDW_ADDR_CFG 5'h00
`define WDW_ADDR_RCTL 5'h04
`define WDW_ADDR_CMD 5'h08
`define WDW_ADDR_STAT 5'h0c
`define WDW_ADDR_MASK 5'h10

// ---------------------------------------------------------------
// Watchdog configuration word fields
// ---------------------------------------------------------------
`define WDW_CFG_POST_LSB 0
`define WDW_CFG_POST_MSB 3
`define WDW_CFG_PRE 4
`define WDW_CFG_WINOFF 6
`define WDW_CFG_HARD 7
`define WDW_CFG_RST 8'h5f

// ---------------------------------------------------------------
// Reset control register fields
// ---------------------------------------------------------------
`define WDW_RCTL_IDLE 2
`define WDW_RCTL_SLEEP 3
`define WDW_RCTL_TMO 4
`define WDW_RCTL_SOFT 5
`define WDW_RCTL_MASK 8'h3c
`define WDW_RCTL_RST 8'h00

// ---------------------------------------------------------------
// Command, status and mask fields
// ---------------------------------------------------------------
`define WDW_CMD_CLR 0
`define WDW_CMD_SLEEP 1
`define WDW_CMD_IDLE 2
`define WDW_ST_TMO 0
`define WDW_ST_WIN 1
`define WDW_ST_WAKE 2
`define WDW_ST_MASK 8'h07
`define WDW_ST_RST 8'h00

// ---------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------
`define WDW_RESP_OKAY 2'h0
`define WDW_RESP_SLVERR 2'h2

`endif

//--- pkg/wdw_pkg.sv
/*
 Types of the windowed watchdog.
 Assumes the constants header is on the include path.
*/
package wdw_pkg;
    `include "wdw_defines.svh"

    // Power mode of the core as seen by the watchdog
    typedef enum logic [2:0] {
        WDW_RUN = 3'h1,
        WDW_SLEEP = 3'h2,
        WDW_IDLE = 3'h4
    } wdw_mode_t;
endpackage

//--- pkg/wdw_cnt_if.sv
/*
 Carrier between the watchdog control, its oscillator tick source and
 its prescaler/postscaler chain.
 Assumes one clock, mclk, shared by all parties.
*/
`timescale 1ns/1ps
interface wdw_cnt_if;
    logic osc_run;
    logic tick;
    logic clr;
    logic pre_sel;
    logic [3:0] post_sel;
    logic timeout;
    logic window_open;

    modport osc (input osc_run, output tick);
    modport cnt (input tick, clr, pre_sel, post_sel,
                 output timeout, window_open);
    modport ctl (output osc_run, clr, pre_sel, post_sel,
                 input tick, timeout, window_open);
endinterface

//--- core/wdw_low_power_rc_oscillator.sv
/*
 Stand-in for the low-power RC oscillator: a one-cycle enable at the
 nominal oscillator rate, derived from mclk.
 Assumes mclk at the rate given in the constants header.
*/
`timescale 1ns/1ps
`include "wdw_defines.svh"
module wdw_osc #(
    parameter int DIV = `WDW_OSC_DIV
) (
    input wire logic mclk,
    input wire logic nrst,
    wdw_cnt_if.osc osc
);
    import wdw_pkg::*;

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    wire at_last = (cnt_q == LAST);

    assign cnt_d = (!osc.osc_run || at_last) ? '0 : cnt_q + 1'b1;
    assign osc.tick = tick_q;

    // -----------------------------------------------------------
    // Divider, runs only while the oscillator is on
    // -----------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= osc.osc_run && at_last;
        end
    end
endmodule // wdw_osc

//--- core/wdw_scaler.sv
/*
 Prescaler and postscaler chain of the watchdog, with timeout pulse
 and the open flag of the last quarter of the period.
 Assumes tick is a one-cycle enable and clr overrides counting.
*/
`timescale 1ns/1ps
`include "wdw_defines.svh"
module wdw_scaler #(
    parameter int PRE_W = `WDW_PRE_SHIFT_HI,
    parameter int POST_W = 15
) (
    input wire logic mclk,
    input wire logic nrst,
    wdw_cnt_if.cnt cnt
);
    import wdw_pkg::*;

    localparam int EW = PRE_W + POST_W + 3;

    logic [PRE_W-1:0] pre_q;
    logic [POST_W-1:0] post_q;
    logic timeout_q;

    // Last value of the prescaler for the selected division
    function automatic logic [PRE_W-1:0] pre_last(input logic sel);
        pre_last = sel ? PRE_W'((1 << `WDW_PRE_SHIFT_HI) - 1)
                       : PRE_W'((1 << `WDW_PRE_SHIFT_LO) - 1);
    endfunction

    // Postscaler ratio; each code doubles the one below
    function automatic logic [POST_W:0] post_ratio(input logic [3:0] s);
        post_ratio = (POST_W+1)'(1) << s;
    endfunction

    wire [PRE_W-1:0] pre_end = pre_last(cnt.pre_sel);
    wire [POST_W:0] ratio = post_ratio(cnt.post_sel);
    wire [POST_W-1:0] post_end = POST_W'(ratio - 1'b1);
    wire pre_wrap = cnt.tick && (pre_q == pre_end);
    wire expire = pre_wrap && (post_q == post_end);
    wire [2:0] sh = cnt.pre_sel ? 3'(`WDW_PRE_SHIFT_HI)
                                : 3'(`WDW_PRE_SHIFT_LO);
    wire [EW-1:0] elapsed = (EW'(post_q) << sh) | EW'(pre_q);
    wire [EW-1:0] total = EW'(ratio) << sh;

    // Open in the last quarter of the period
    assign cnt.window_open = (elapsed << 2) >= (total * 3);
    assign cnt.timeout = timeout_q;

    // -----------------------------------------------------------
    // Counters
    // -----------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= '0;
            post_q <= '0;
            timeout_q <= 1'b0;
        end else if (cnt.clr) begin
            pre_q <= '0;
            post_q <= '0;
            timeout_q <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? '0 : pre_q + PRE_W'(cnt.tick);
            post_q <= expire ? '0 : post_q + POST_W'(pre_wrap);
            timeout_q <= expire;
        end
    end
endmodule // wdw_scaler

//--- verif/wdw_top_chk.sv
/*
 Checker on the ports of the watchdog top.
 Assumes a bind into wdw_top and one clock, mclk.
*/
`timescale 1ns/1ps
`include "wdw_defines.svh"
module wdw_top_chk #(
    parameter int AW = 5
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wake_event,
    input wire logic wdt_reset,
    input wire wdw_pkg::wdw_mode_t power_mode,
    input wire logic irq
);
    import wdw_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    wire aw_go = s_axi_awvalid && s_axi_awready;
    wire cmd_go = aw_go && s_axi_wstrb[0] && s_axi_awaddr == `WDW_ADDR_CMD;
    property p_b_ans;
        aw_go |=> s_axi_bvalid;
    endproperty
    a_b_ans: assert property (p_b_ans) else $error("write not answered");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer lost");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read not answered");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data lost");
    property p_err;
        aw_go && s_axi_awaddr > `WDW_ADDR_MASK |=> s_axi_bresp == `WDW_RESP_SLVERR;
    endproperty
    a_err: assert property (p_err) else $error("unmapped write accepted");
    property p_one;
        wdt_reset |=> !wdt_reset;
    endproperty
    a_one: assert property (p_one) else $error("reset pulse too long");
    property p_nrun;
        power_mode != WDW_RUN |=> !wdt_reset;
    endproperty
    a_nrun: assert property (p_nrun) else $error("reset while asleep");
    property p_wake;
        power_mode != WDW_RUN && wake_event |=> power_mode == WDW_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_sleep;
        cmd_go && s_axi_wdata[`WDW_CMD_SLEEP] && power_mode == WDW_RUN
            |=> power_mode == WDW_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
endmodule // wdw_top_chk

bind wdw_top wdw_top_chk #(.AW(AW)) u_chk (.mclk(mclk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wake_event(wake_event),
    .wdt_reset(wdt_reset), .power_mode(power_mode), .irq(irq));

//--- verif/wdw_top_test.sv
/*
 Self-checking bench of the watchdog top.
 Assumes the package, header and design files are compiled first.
*/
`timescale 1ns/1ps
`include "wdw_defines.svh"
module wdw_top_test;
    import wdw_pkg::*;
    localparam int DIV = 4;
    logic mclk, nrst, awv, wv, bv, br, arv, arr, rv, rr, aw_r, w_r;
    logic [4:0] awa, ara;
    logic [31:0] wd, rd_d;
    logic [3:0] ws;
    logic [1:0] bresp, rresp;
    logic dev_rst, clk_sw, wake, osc_on, wdt_reset, irq;
    wdw_mode_t pm;
    int bad_count = 0, checks_done = 0, cyc = 0, seed = 48, seen = 0, n;
    logic [33:0] exp_q[$];
    logic [7:0] tbl[4] = '{8'hc0, 8'hc1, 8'hc2, 8'hd0};
    wdw_top #(.OSC_DIV(DIV)) DUT (.mclk(mclk), .nrst(nrst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_r),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .dev_reset_req(dev_rst),
        .clk_switch_done(clk_sw), .wake_event(wake), .osc_on(osc_on),
        .wdt_reset(wdt_reset), .power_mode(pm), .irq(irq));
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(string w, logic [33:0] e, logic [33:0] s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", w, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // -------------------------------------------------------------
    // Bus master and monitor
    // -------------------------------------------------------------
    task automatic wr(logic [4:0] a, logic [7:0] d, logic [1:0] er);
        @(posedge mclk);
        awa <= a;
        wd <= {24'($random(seed)), d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(posedge mclk); while (!(aw_r && w_r));
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge mclk); while (!bv);
        br <= 1'b0;
        chk("bresp", 34'(er), 34'(bresp));
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] e, logic [1:0] er);
        @(posedge mclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        exp_q.push_back({er, 24'h0, e});
        do @(posedge mclk); while (!arr);
        arv <= 1'b0;
        do @(posedge mclk); while (!rv);
        rr <= 1'b0;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (wdt_reset === 1'b1) seen++;
        if (rv === 1'b1 && rr === 1'b1 && exp_q.size() > 0)
            chk("rdata", exp_q.pop_front(), {rresp, rd_d});
        if (cyc == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    // -------------------------------------------------------------
    // Period helpers
    // -------------------------------------------------------------
    task automatic kick(int k);
        if (k == 0) begin
            wr(`WDW_ADDR_CMD, 8'h01, `WDW_RESP_OKAY);
        end else begin
            @(posedge mclk);
            clk_sw <= (k == 1);
            dev_rst <= (k == 2);
            @(posedge mclk);
            clk_sw <= 1'b0;
            dev_rst <= 1'b0;
        end
    endtask
    task automatic wait_rst();
        n = 0;
        while (wdt_reset !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic near(logic [7:0] c);
        int e;
        e = ((c[4] ? 128 : 32) << c[3:0]) * DIV;
        chk("period", 1, 34'(n >= e - 12 && n <= e + 12));
    endtask
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        {nrst, awv, wv, br, arv, rr, dev_rst, clk_sw, wake} = '0;
        {awa, ara, wd} = '0;
        ws = 4'hf;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rd(`WDW_ADDR_CFG, 8'h5f, `WDW_RESP_OKAY);
        rd(`WDW_ADDR_RCTL, 8'h00, `WDW_RESP_OKAY);
        rd(5'h14, 8'h00, `WDW_RESP_SLVERR);
        chk("osc_on", 0, 34'(osc_on));
        wr(`WDW_ADDR_CFG, 8'h40, `WDW_RESP_OKAY);
        wr(`WDW_ADDR_RCTL, 8'h20, `WDW_RESP_OKAY);
        chk("osc_on", 1, 34'(osc_on));
        kick(0);
        wait_rst();
        near(8'h40);
        @(posedge mclk);
        chk("irq", 0, 34'(irq));
        wr(`WDW_ADDR_MASK, 8'h07, `WDW_RESP_OKAY);
        chk("irq", 1, 34'(irq));
        rd(`WDW_ADDR_RCTL, 8'h10, `WDW_RESP_OKAY);
        rd(`WDW_ADDR_STAT, 8'h01, `WDW_RESP_OKAY);
        chk("irq", 0, 34'(irq));
        chk("osc_on", 0, 34'(osc_on));
        for (int i = 0; i < 4; i++) begin
            wr(`WDW_ADDR_CFG, tbl[i], `WDW_RESP_OKAY);
            kick(0);
            repeat (50 + {$random(seed)} % 60) @(posedge mclk);
            kick(i % 3);
            wait_rst();
            near(tbl[i]);
        end
        wr(`WDW_ADDR_RCTL, 8'h00, `WDW_RESP_OKAY);
        chk("osc_on", 1, 34'(osc_on));
        wr(`WDW_ADDR_CFG, 8'h80, `WDW_RESP_OKAY);
        kick(1);
        repeat (40) @(posedge mclk);
        kick(0);
        wait_rst();
        chk("early", 1, 34'(n <= 4));
        kick(1);
        repeat (112) @(posedge mclk);
        kick(0);
        wait_rst();
        chk("late", 1, 34'(n >= 100));
        wr(`WDW_ADDR_CFG, 8'hc0, `WDW_RESP_OKAY);
        wr(`WDW_ADDR_RCTL, 8'h00, `WDW_RESP_OKAY);
        n = seen;
        wr(`WDW_ADDR_CMD, 8'h02, `WDW_RESP_OKAY);
        chk("mode", 34'(WDW_SLEEP), 34'(pm));
        repeat (200) @(posedge mclk);
        chk("mode", 34'(WDW_RUN), 34'(pm));
        chk("resets", 34'(n), 34'(seen));
        rd(`WDW_ADDR_RCTL, 8'h18, `WDW_RESP_OKAY);
        wr(`WDW_ADDR_RCTL, 8'h00, `WDW_RESP_OKAY);
        wr(`WDW_ADDR_CMD, 8'h04, `WDW_RESP_OKAY);
        chk("mode", 34'(WDW_IDLE), 34'(pm));
        repeat (60) @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        wait_rst();
        near(8'hc0);
        rd(`WDW_ADDR_RCTL, 8'h14, `WDW_RESP_OKAY);
        wrap_up();
    end
endmodule // wdw_top_test
